// file: bench/gss_engine_model.sv
// Behavioural drawing engine: control byte, part lengths and the two state data ports.
// Assumes the host holds each strobe until it has seen the acknowledge, four-phase.
`timescale 1ns/1ps
`default_nettype none
module gss_engine_model #(
	parameter int LA = 3,
	parameter int LB = 2
) (
	input wire logic clk_i, // System clock.
	input wire logic rst_i, // Asynchronous reset, active high.
	input wire logic [2:0] lat_i, // Extra answer delay in cycles.
	input wire logic [6:0] dev_addr_i, // Word address or port index.
	input wire logic dev_io_i, // Data port space select.
	input wire logic [3:0] dev_be_i, // Byte enables.
	input wire logic [31:0] dev_wdata_i, // Write data.
	input wire logic dev_wr_i, // Write strobe.
	input wire logic dev_rd_i, // Read strobe.
	output logic [31:0] dev_rdata_o, // Read data.
	output logic dev_ack_o // Acknowledge.
);
	logic active_q, abort_q, halted_q, halt_req_q, dir_q;
	logic [1:0] kind_q, ph_q;
	// Effect delay, longer than the quickest poll, so the host's retry path is exercised.
	logic [4:0] tmr_q;
	logic [2:0] cnt_q;
	int ia_q, ib_q, flush_n;
	logic [31:0] mem_a [LA];
	logic [31:0] mem_b [LB];
	logic [7:0] wb, ctl;
	logic ctl_hit;
	// Control byte as seen on a read, and the decode of a control write.
	assign ctl = {active_q, 1'h0, abort_q, halted_q, halt_req_q, 1'h0, dir_q, 1'h0};
	assign wb = dev_wdata_i[15:8];
	assign ctl_hit = !dev_io_i && dev_addr_i == 7'h10;
	// Handshake, decode and delayed effects; effects land late so the host must poll.
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			{active_q, abort_q, halted_q, halt_req_q, dir_q} <= 5'h10;
			{kind_q, ph_q, tmr_q, cnt_q} <= 12'h000;
			dev_rdata_o <= 32'h0000_0000;
			dev_ack_o <= 1'h0;
			ia_q <= 0;
			ib_q <= 0;
			flush_n <= 0;
			for (int i = 0; i < LA; i++) mem_a[i] <= 32'h00A0_0000 + 32'(i);
			for (int i = 0; i < LB; i++) mem_b[i] <= 32'h00B0_0000 + 32'(i);
		end else begin
			if (tmr_q == 5'h01 && kind_q == 2'h0) begin
				{active_q, abort_q, halted_q, halt_req_q, dir_q} <= 5'h00;
			end
			if (tmr_q == 5'h01 && kind_q == 2'h1) begin
				halted_q <= 1'h1;
				flush_n <= flush_n + 1;
			end
			if (tmr_q == 5'h01 && kind_q == 2'h2) halted_q <= 1'h0;
			if (tmr_q != 5'h00) tmr_q <= tmr_q - 5'h01;
			case (ph_q)
			2'h0: if (dev_wr_i || dev_rd_i) begin
				cnt_q <= lat_i;
				ph_q <= 2'h1;
			end
			2'h1: if (cnt_q != 3'h0) begin
				cnt_q <= cnt_q - 3'h1;
			end else begin
				ph_q <= 2'h3;
				dev_rdata_o <= ~dev_rdata_o;
				if (dev_io_i && dev_addr_i == 7'h0C) begin
					if (ia_q < LA) dev_rdata_o <= mem_a[ia_q];
					if (ia_q < LA && dev_wr_i) mem_a[ia_q] <= dev_wdata_i;
					ia_q <= ia_q + 1;
				end
				if (dev_io_i && dev_addr_i == 7'h0D) begin
					if (ib_q < LB) dev_rdata_o <= mem_b[ib_q];
					if (ib_q < LB && dev_wr_i) mem_b[ib_q] <= dev_wdata_i;
					ib_q <= ib_q + 1;
				end
				if (!dev_io_i && dev_addr_i == 7'h0C) dev_rdata_o <= {16'h0000, 8'(LB), 8'(LA)};
				if (ctl_hit) dev_rdata_o <= {16'h0000, ctl, 8'h00};
				if (ctl_hit && dev_wr_i && dev_be_i[1]) begin
					ia_q <= 0;
					ib_q <= 0;
					if (wb[5]) begin
						abort_q <= 1'h1;
						kind_q <= 2'h0;
						tmr_q <= 5'h14;
					end else if (wb[3]) begin
						halt_req_q <= 1'h1;
						dir_q <= wb[1];
						kind_q <= 2'h1;
						tmr_q <= 5'h14;
					end else begin
						halt_req_q <= 1'h0;
						kind_q <= 2'h2;
						tmr_q <= 5'h14;
					end
				end
			end
			2'h3: begin
				dev_ack_o <= 1'h1;
				ph_q <= 2'h2;
			end
			default: if (!dev_wr_i && !dev_rd_i) begin
				dev_ack_o <= 1'h0;
				dev_rdata_o <= ~dev_rdata_o;
				ph_q <= 2'h0;
			end
			endcase
		end
	end
endmodule
`default_nettype wire

// file: bench/testbench.sv
// Self-checking bench: abort, save, resume and restore against the engine model.
// Assumes gss_pkg, gss_host_ctrl and gss_engine_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam int LA = 3;
	localparam int LB = 2;
	logic clk_i, rst_i, cmd_valid_i, regs_reprog_i, sv_ready_i, rs_valid_i, take, dev_ack_i;
	logic cmd_ready_o, busy_o, done_o, err_o, regs_stale_o, sv_valid_o, sv_part_o, rs_ready_o;
	logic dev_io_o, dev_wr_o, dev_rd_o;
	logic [1:0] cmd_op_i;
	logic [2:0] lat;
	logic [3:0] dev_be_o;
	logic [6:0] dev_addr_o;
	logic [31:0] rs_data_i, dev_rdata_i, sv_data_o, dev_wdata_o;
	logic [31:0] ma [LA];
	logic [31:0] mb [LB];
	logic [32:0] svq[$];
	logic [1:0] endq[$];
	logic [31:0] rsq[$];
	int seed = 84398;
	int bad_count = 0;
	int checks = 0;

	gss_host_ctrl #(.POLL_MAX(8)) DUT (.clk_i, .rst_i, .cmd_valid_i, .cmd_op_i, .cmd_ready_o,
		.busy_o, .done_o, .err_o, .regs_stale_o, .regs_reprog_i, .sv_valid_o, .sv_data_o,
		.sv_part_o, .sv_ready_i, .rs_valid_i, .rs_data_i, .rs_ready_o, .dev_addr_o, .dev_io_o,
		.dev_be_o, .dev_wdata_o, .dev_wr_o, .dev_rd_o, .dev_rdata_i, .dev_ack_i);
	gss_engine_model #(.LA(LA), .LB(LB)) ENG (.clk_i, .rst_i, .lat_i(lat),
		.dev_addr_i(dev_addr_o), .dev_io_i(dev_io_o), .dev_be_i(dev_be_o),
		.dev_wdata_i(dev_wdata_o), .dev_wr_i(dev_wr_o), .dev_rd_i(dev_rd_o),
		.dev_rdata_o(dev_rdata_i), .dev_ack_o(dev_ack_i));

	// Clock at 200 MHz.
	initial begin
		clk_i = 1'h0;
		forever #2.5 clk_i = ~clk_i;
	end

	task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic tally_and_finish();
		if (bad_count == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// Offer one command, then wait a bounded time for its end pulse.
	task automatic run(input logic [1:0] op);
		int n;
		n = 0;
		endq.push_back(2'h2);
		@(posedge clk_i);
		#1 cmd_op_i = op;
		cmd_valid_i = 1'h1;
		do @(negedge clk_i); while (cmd_ready_o !== 1'h1);
		@(posedge clk_i);
		#1 cmd_valid_i = 1'h0;
		chk("busy", 33'(busy_o), 33'h1);
		do begin
			@(negedge clk_i);
			n++;
		end while (done_o !== 1'h1 && err_o !== 1'h1 && n < 4000);
		if (n >= 4000) begin
			bad_count++;
			tally_and_finish();
		end
	endtask

	// Receiver stalls, engine delays and the restore stream change just after each edge.
	always @(posedge clk_i) begin
		#1;
		sv_ready_i = 1'($random(seed));
		lat = 3'($random(seed));
		if (take) void'(rsq.pop_front());
		rs_valid_i = rsq.size() != 0;
		if (rsq.size() != 0) rs_data_i = rsq[0];
	end
	always @(negedge clk_i) take = rs_valid_i && rs_ready_o === 1'h1;

	// Watcher: each end pulse and each accepted saved word is matched to the oldest note.
	always @(negedge clk_i) begin
		if (done_o === 1'h1 || err_o === 1'h1) chk("end", 33'({done_o, err_o}), 33'(endq.pop_front()));
		if (sv_valid_o === 1'h1 && sv_ready_i) chk("saved word", {sv_part_o, sv_data_o}, svq.pop_front());
	end

	// Main sequence: reset, abort, then two rounds of save, resume, restore, resume.
	initial begin
		{rst_i, cmd_valid_i, regs_reprog_i} = 3'h4;
		cmd_op_i = 2'h0;
		for (int i = 0; i < LA; i++) ma[i] = 32'h00A0_0000 + 32'(i);
		for (int i = 0; i < LB; i++) mb[i] = 32'h00B0_0000 + 32'(i);
		repeat (6) @(posedge clk_i);
		chk("ready in reset", 33'(cmd_ready_o), 33'h0);
		#1 rst_i = 1'h0;
		run(gss_pkg::OP_ABORT);
		chk("stale", 33'(regs_stale_o), 33'h1);
		chk("abort and active", 33'({ENG.abort_q, ENG.active_q}), 33'h0);
		@(posedge clk_i);
		#1 regs_reprog_i = 1'h1;
		@(posedge clk_i);
		#1 regs_reprog_i = 1'h0;
		@(negedge clk_i);
		chk("stale cleared", 33'(regs_stale_o), 33'h0);
		for (int k = 0; k < 2; k++) begin
			foreach (ma[i]) svq.push_back({1'h0, ma[i]});
			foreach (mb[i]) svq.push_back({1'h1, mb[i]});
			run(gss_pkg::OP_SAVE);
			chk("halt and save dir", 33'({ENG.halted_q, ENG.dir_q}), 33'h3);
			chk("flushes", 33'(ENG.flush_n), 33'(2 * k + 1));
			// Done comes before the buffer empties when the receiver stalls; let it drain.
			for (int w = 0; w < 64 && svq.size() != 0; w++) @(negedge clk_i);
			chk("save drained", 33'(svq.size()), 33'h0);
			run(gss_pkg::OP_RESUME);
			chk("halted after resume", 33'(ENG.halted_q), 33'h0);
			foreach (ma[i]) begin
				ma[i] = $random(seed);
				rsq.push_back(ma[i]);
			end
			foreach (mb[i]) begin
				mb[i] = $random(seed);
				rsq.push_back(mb[i]);
			end
			run(gss_pkg::OP_RESTORE);
			chk("restore dir", 33'({ENG.halted_q, ENG.dir_q}), 33'h2);
			chk("restore used", 33'(rsq.size()), 33'h0);
			run(gss_pkg::OP_RESUME);
		end
		tally_and_finish();
	end

	// Watchdog well beyond the expected run length.
	initial begin
		#100000;
		bad_count++;
		tally_and_finish();
	end
endmodule
`default_nettype wire

// file: hdl/gss_buf.sv
// Small shift-register FIFO between the save reader and the user stream.
// Assumes one clock; head entry and flags are registers so outputs leave from flops.
`timescale 1ns/1ps
`default_nettype none
module gss_buf #(
	parameter int unsigned W = 32,
	parameter int unsigned DEPTH = 2
) (
	input wire logic clk_i, // System clock.
	input wire logic rst_i, // Asynchronous reset, active high.
	input wire logic in_valid_i, // Word offered.
	input wire logic [W-1:0] in_data_i, // Word offered.
	output logic in_ready_o, // Room for a word.
	output logic out_valid_o, // Head word present.
	output logic [W-1:0] out_data_o, // Head word.
	input wire logic out_ready_i // Drain accepts head.
);

	localparam int unsigned CW = $clog2(DEPTH + 1);
	logic [W-1:0] mem_q [DEPTH];
	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;
	logic [CW-1:0] wr_idx;
	logic push;
	logic pop;
	logic rdy_q;
	logic vld_q;

	// Handshakes use the registered flags, so full and empty are exact.
	always_comb begin
		push = in_valid_i && rdy_q;
		pop = vld_q && out_ready_i;
		wr_idx = cnt_q - CW'(pop);
		cnt_d = cnt_q + CW'(push) - CW'(pop);
	end

	// Entries shift toward the head on a pop; order is kept first in first out.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_q[i] <= '0;
			end
		end else begin
			for (int i = 0; i < DEPTH; i++) begin
				if (push && (wr_idx == CW'(i))) begin
					mem_q[i] <= in_data_i;
				end else if (pop && (i < DEPTH - 1)) begin
					mem_q[i] <= mem_q[(i + 1) % DEPTH];
				end
			end
		end
	end

	// Occupancy and the flags derived from it.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_q <= '0;
			rdy_q <= 1'b0;
			vld_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			rdy_q <= (cnt_d != CW'(DEPTH));
			vld_q <= (cnt_d != '0);
		end
	end

	assign in_ready_o = rdy_q;
	assign out_valid_o = vld_q;
	assign out_data_o = mem_q[0];

endmodule
`default_nettype wire

// file: hdl/gss_host_ctrl.sv
// Host-side controller that aborts, halts, saves, restores and resumes the drawing engine.
// Assumes the engine answers each strobe with ack held high until the strobe falls,
// with read data stable before ack rises.
`timescale 1ns/1ps
`default_nettype none
module gss_host_ctrl #(
	parameter int unsigned POLL_MAX = gss_pkg::POLL_MAX_DEF,
	parameter int unsigned BUF_DEPTH = gss_pkg::BUF_DEPTH
) (
	input wire logic clk_i, // System clock, 200 MHz.
	input wire logic rst_i, // Asynchronous reset, active high.
	input wire logic cmd_valid_i, // Command offered.
	input wire logic [1:0] cmd_op_i, // Command code.
	output logic cmd_ready_o, // Command taken when high with valid.
	output logic busy_o, // A command is in progress.
	output logic done_o, // One-cycle pulse at command end.
	output logic err_o, // One-cycle pulse on poll timeout.
	output logic regs_stale_o, // Engine registers need reprogramming.
	input wire logic regs_reprog_i, // Pulse: user has reprogrammed them.
	output logic sv_valid_o, // Saved word available.
	output logic [31:0] sv_data_o, // Saved word.
	output logic sv_part_o, // Saved word belongs to part B.
	input wire logic sv_ready_i, // User takes saved word.
	input wire logic rs_valid_i, // Restore word offered.
	input wire logic [31:0] rs_data_i, // Restore word.
	output logic rs_ready_o, // Restore word taken when high with valid.
	output logic [6:0] dev_addr_o, // Engine word address.
	output logic dev_io_o, // One selects the I/O data port space.
	output logic [3:0] dev_be_o, // Engine byte enables.
	output logic [31:0] dev_wdata_o, // Engine write data.
	output logic dev_wr_o, // Engine write strobe.
	output logic dev_rd_o, // Engine read strobe.
	input wire logic [31:0] dev_rdata_i, // Engine read data.
	input wire logic dev_ack_i // Engine acknowledge.
);

	localparam int unsigned PW = $clog2(POLL_MAX + 1);
	localparam int unsigned LW = gss_pkg::LEN_W;

	typedef enum logic [11:0] {
		ST_IDLE = 12'h001,
		ST_CTLW = 12'h002,
		ST_POLL = 12'h004,
		ST_CHK = 12'h008,
		ST_LENR = 12'h010,
		ST_LENLD = 12'h020,
		ST_NEXTW = 12'h040,
		ST_FILL = 12'h080,
		ST_XFER = 12'h100,
		ST_ACK = 12'h200,
		ST_REL = 12'h400,
		ST_PUSH = 12'h800
	} gss_state_t;

	gss_state_t state_q;
	gss_state_t nxt_q;
	gss_pkg::gss_op_t op_q;
	logic [PW-1:0] poll_q;
	logic [LW-1:0] cnt_q;
	logic [LW-1:0] len_a_q;
	logic [LW-1:0] len_b_q;
	logic part_q;
	logic [31:0] rdat_q;
	logic [31:0] wrd_q;
	logic rs_ready_q;
	logic buf_in_valid_q;
	logic [32:0] buf_in_data_q;
	logic buf_in_ready;
	logic [32:0] buf_out;
	logic [32:0] sync_out;
	logic ack_s;
	logic [31:0] rdata_s;
	logic start;
	logic ack_hi;
	logic poll_ok;
	logic xfer_wr;
	logic last_word;
	logic [7:0] ctrl_rd;
	logic [7:0] ctrl_w;
	logic cmd_ready_q;
	logic busy_q;
	logic done_q;
	logic err_q;
	logic stale_q;
	logic halted_seen_q;
	logic [LW:0] xcnt_q;
	logic [6:0] dev_addr_q;
	logic dev_io_q;
	logic [3:0] dev_be_q;
	logic [31:0] dev_wdata_q;
	logic dev_wr_q;
	logic dev_rd_q;

	// Acknowledge and read data come from the engine pins, so both are synchronised.
	gss_sync #(
		.W(33)
	) u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i({dev_ack_i, dev_rdata_i}),
		.q_o(sync_out)
	);
	assign ack_s = sync_out[32];
	assign rdata_s = sync_out[31:0];

	// Decisions shared by the processes below.
	always_comb begin
		start = (state_q == ST_IDLE) && cmd_valid_i && cmd_ready_q;
		ack_hi = (state_q == ST_ACK) && ack_s;
		xfer_wr = (op_q == gss_pkg::OP_RESTORE);
		last_word = (state_q == ST_NEXTW) && (cnt_q == '0) && part_q;
		ctrl_rd = rdat_q[8*gss_pkg::CTRL_LANE +: 8];
		ctrl_w = 8'h00;
		poll_ok = 1'b0;
		unique case (op_q)
			gss_pkg::OP_ABORT: begin
				ctrl_w[gss_pkg::BIT_ABORT] = 1'b1;
				poll_ok = !ctrl_rd[gss_pkg::BIT_ACTIVE] && !ctrl_rd[gss_pkg::BIT_ABORT];
			end
			gss_pkg::OP_SAVE: begin
				ctrl_w[gss_pkg::BIT_HALT_REQ] = 1'b1;
				ctrl_w[gss_pkg::BIT_DIR] = 1'b1;
				poll_ok = ctrl_rd[gss_pkg::BIT_HALTED];
			end
			gss_pkg::OP_RESTORE: begin
				ctrl_w[gss_pkg::BIT_HALT_REQ] = 1'b1;
				poll_ok = ctrl_rd[gss_pkg::BIT_HALTED];
			end
			gss_pkg::OP_RESUME: begin
				poll_ok = !ctrl_rd[gss_pkg::BIT_HALTED];
			end
		endcase
	end

	// Sequencer. Every engine access goes through ACK and REL, a four-phase handshake.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_q <= ST_IDLE;
			nxt_q <= ST_IDLE;
		end else begin
			unique case (state_q)
				ST_IDLE: begin
					if (start) begin
						state_q <= ST_CTLW;
					end
				end
				ST_CTLW: begin
					state_q <= ST_ACK;
					nxt_q <= ST_POLL;
				end
				ST_POLL: begin
					state_q <= ST_ACK;
					nxt_q <= ST_CHK;
				end
				ST_CHK: begin
					if (poll_ok) begin
						state_q <= (op_q == gss_pkg::OP_SAVE || xfer_wr) ? ST_LENR : ST_IDLE;
					end else if (poll_q == PW'(POLL_MAX)) begin
						state_q <= ST_IDLE;
					end else begin
						state_q <= ST_POLL;
					end
				end
				ST_LENR: begin
					state_q <= ST_ACK;
					nxt_q <= ST_LENLD;
				end
				ST_LENLD: state_q <= ST_NEXTW;
				ST_NEXTW: begin
					if (cnt_q == '0) begin
						state_q <= part_q ? ST_IDLE : ST_NEXTW;
					end else begin
						state_q <= xfer_wr ? ST_FILL : ST_XFER;
					end
				end
				ST_FILL: begin
					if (rs_valid_i && rs_ready_q) begin
						state_q <= ST_XFER;
					end
				end
				ST_XFER: begin
					state_q <= ST_ACK;
					nxt_q <= xfer_wr ? ST_NEXTW : ST_PUSH;
				end
				ST_ACK: begin
					if (ack_s) begin
						state_q <= ST_REL;
					end
				end
				ST_REL: begin
					if (!ack_s) begin
						state_q <= nxt_q;
					end
				end
				ST_PUSH: begin
					if (buf_in_valid_q && buf_in_ready) begin
						state_q <= ST_NEXTW;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// Command, poll budget, lengths and word counts. Counts stop at zero, never wrap.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			op_q <= gss_pkg::OP_ABORT;
			poll_q <= '0;
			cnt_q <= '0;
			len_a_q <= '0;
			len_b_q <= '0;
			part_q <= 1'b0;
		end else begin
			if (start) begin
				op_q <= gss_pkg::gss_op_t'(cmd_op_i);
				poll_q <= '0;
			end else if (state_q == ST_CHK && !poll_ok) begin
				poll_q <= poll_q + PW'(1);
			end
			if (state_q == ST_LENLD) begin
				len_a_q <= rdat_q[8*gss_pkg::LENA_LANE +: LW];
				len_b_q <= rdat_q[8*gss_pkg::LENB_LANE +: LW];
				cnt_q <= rdat_q[8*gss_pkg::LENA_LANE +: LW];
				part_q <= 1'b0;
			end else if (state_q == ST_NEXTW && cnt_q == '0 && !part_q) begin
				cnt_q <= len_b_q;
				part_q <= 1'b1;
			end else if (state_q == ST_XFER) begin
				cnt_q <= cnt_q - LW'(1);
			end
		end
	end

	// Engine pins. Only the control byte, the length word and the two ports are touched.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			dev_addr_q <= '0;
			dev_io_q <= 1'b0;
			dev_be_q <= '0;
			dev_wdata_q <= '0;
			dev_wr_q <= 1'b0;
			dev_rd_q <= 1'b0;
			rdat_q <= '0;
		end else if (state_q == ST_CTLW || state_q == ST_POLL) begin
			dev_addr_q <= {gss_pkg::CTRL_OFF[6:2], 2'b00};
			dev_io_q <= 1'b0;
			dev_be_q <= gss_pkg::BE_ONE << gss_pkg::CTRL_LANE;
			dev_wdata_q <= 32'(ctrl_w) << (8 * gss_pkg::CTRL_LANE);
			dev_wr_q <= (state_q == ST_CTLW);
			dev_rd_q <= (state_q == ST_POLL);
		end else if (state_q == ST_LENR) begin
			dev_addr_q <= {gss_pkg::LEN_A_OFF[6:2], 2'b00};
			dev_io_q <= 1'b0;
			dev_be_q <= (gss_pkg::BE_ONE << gss_pkg::LENA_LANE) | (gss_pkg::BE_ONE << gss_pkg::LENB_LANE);
			dev_rd_q <= 1'b1;
		end else if (state_q == ST_XFER) begin
			dev_addr_q <= part_q ? gss_pkg::PORT_B_IDX : gss_pkg::PORT_A_IDX;
			dev_io_q <= 1'b1;
			dev_be_q <= gss_pkg::BE_ALL;
			dev_wdata_q <= wrd_q;
			dev_wr_q <= xfer_wr;
			dev_rd_q <= !xfer_wr;
		end else if (ack_hi) begin
			dev_wr_q <= 1'b0;
			dev_rd_q <= 1'b0;
			rdat_q <= rdata_s;
		end
	end

	// Word streams. Saved words go through the buffer so a stalled user loses nothing.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wrd_q <= '0;
			rs_ready_q <= 1'b0;
			buf_in_valid_q <= 1'b0;
			buf_in_data_q <= '0;
		end else begin
			rs_ready_q <= (state_q == ST_FILL) && !(rs_valid_i && rs_ready_q);
			if (state_q == ST_FILL && rs_valid_i && rs_ready_q) begin
				wrd_q <= rs_data_i;
			end
			if (state_q == ST_REL && !ack_s && nxt_q == ST_PUSH) begin
				buf_in_valid_q <= 1'b1;
				buf_in_data_q <= {part_q, rdat_q};
			end else if (buf_in_ready) begin
				buf_in_valid_q <= 1'b0;
			end
		end
	end

	gss_buf #(
		.W(33),
		.DEPTH(BUF_DEPTH)
	) u_buf (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.in_valid_i(buf_in_valid_q),
		.in_data_i(buf_in_data_q),
		.in_ready_o(buf_in_ready),
		.out_valid_o(sv_valid_o),
		.out_data_o(buf_out),
		.out_ready_i(sv_ready_i)
	);
	assign sv_data_o = buf_out[31:0];
	assign sv_part_o = buf_out[32];

	// Status flags. The stale flag's set wins over a same-cycle clear.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cmd_ready_q <= 1'b0;
			busy_q <= 1'b0;
			done_q <= 1'b0;
			err_q <= 1'b0;
			stale_q <= 1'b0;
			halted_seen_q <= 1'b0;
			xcnt_q <= '0;
		end else begin
			cmd_ready_q <= (state_q == ST_IDLE) && !start;
			busy_q <= !((state_q == ST_IDLE) && !start);
			done_q <= last_word || (state_q == ST_CHK && poll_ok && op_q != gss_pkg::OP_SAVE
				&& !xfer_wr);
			err_q <= (state_q == ST_CHK) && !poll_ok && (poll_q == PW'(POLL_MAX));
			if (state_q == ST_CHK && poll_ok && op_q == gss_pkg::OP_ABORT) begin
				stale_q <= 1'b1;
			end else if (regs_reprog_i) begin
				stale_q <= 1'b0;
			end
			if (start) begin
				halted_seen_q <= 1'b0;
				xcnt_q <= '0;
			end else begin
				if (state_q == ST_CHK && poll_ok) begin
					halted_seen_q <= (op_q == gss_pkg::OP_SAVE) || xfer_wr;
				end
				if (state_q == ST_XFER) begin
					xcnt_q <= xcnt_q + (LW + 1)'(1);
				end
			end
		end
	end

	assign cmd_ready_o = cmd_ready_q;
	assign busy_o = busy_q;
	assign done_o = done_q;
	assign err_o = err_q;
	assign regs_stale_o = stale_q;
	assign rs_ready_o = rs_ready_q;
	assign dev_addr_o = dev_addr_q;
	assign dev_io_o = dev_io_q;
	assign dev_be_o = dev_be_q;
	assign dev_wdata_o = dev_wdata_q;
	assign dev_wr_o = dev_wr_q;
	assign dev_rd_o = dev_rd_q;

	// Checks on what the controller drives toward the engine and the user.
	sequence s_abort_req;
		start && cmd_op_i == gss_pkg::OP_ABORT;
	endsequence
	sequence s_abort_wr;
		dev_wr_q && dev_wdata_q[8*gss_pkg::CTRL_LANE + gss_pkg::BIT_ABORT];
	endsequence
	property p_abort_write;
		@(posedge clk_i) disable iff (rst_i) s_abort_req |-> ##2 s_abort_wr;
	endproperty
	a_abort_write: assert property (p_abort_write) else $error("abort write missing");
	property p_abort_bit_wait;
		@(posedge clk_i) disable iff (rst_i)
		(state_q == ST_CHK && op_q == gss_pkg::OP_ABORT && ctrl_rd[gss_pkg::BIT_ABORT]) |=> !done_q;
	endproperty
	a_abort_bit_wait: assert property (p_abort_bit_wait) else $error("done before abort cleared");
	property p_abort_busy_wait;
		@(posedge clk_i) disable iff (rst_i)
		(state_q == ST_CHK && op_q == gss_pkg::OP_ABORT && ctrl_rd[gss_pkg::BIT_ACTIVE])
		|=> (state_q == ST_POLL || err_q) && !done_q;
	endproperty
	a_abort_busy_wait: assert property (p_abort_busy_wait) else $error("abort not polled");
	property p_stale_after_abort;
		@(posedge clk_i) disable iff (rst_i)
		(done_q && op_q == gss_pkg::OP_ABORT) |-> stale_q;
	endproperty
	a_stale_after_abort: assert property (p_stale_after_abort) else $error("stale flag not set");
	property p_port_after_halt;
		@(posedge clk_i) disable iff (rst_i) ((dev_rd_q || dev_wr_q) && dev_io_q) |-> halted_seen_q;
	endproperty
	a_port_after_halt: assert property (p_port_after_halt) else $error("port used unhalted");
	property p_ctl_fields;
		@(posedge clk_i) disable iff (rst_i)
		(dev_wr_q && !dev_io_q && op_q != gss_pkg::OP_ABORT) |->
		dev_wdata_q[8*gss_pkg::CTRL_LANE + gss_pkg::BIT_HALT_REQ] == (op_q != gss_pkg::OP_RESUME) &&
		dev_wdata_q[8*gss_pkg::CTRL_LANE + gss_pkg::BIT_DIR] == (op_q == gss_pkg::OP_SAVE);
	endproperty
	a_ctl_fields: assert property (p_ctl_fields) else $error("control fields wrong");
	property p_count_exact;
		@(posedge clk_i) disable iff (rst_i)
		(done_q && (op_q == gss_pkg::OP_SAVE || xfer_wr)) |-> xcnt_q == ({1'b0, len_a_q} + {1'b0, len_b_q});
	endproperty
	a_count_exact: assert property (p_count_exact) else $error("word count mismatch");
	property p_zero_reserved;
		@(posedge clk_i) disable iff (rst_i)
		(dev_wr_q && !dev_io_q) |-> (dev_wdata_q[8*gss_pkg::CTRL_LANE +: 8] & gss_pkg::CTRL_ZERO_MASK) == 8'h00;
	endproperty
	a_zero_reserved: assert property (p_zero_reserved) else $error("reserved bit written");
	property p_legal_addr;
		@(posedge clk_i) disable iff (rst_i)
		(dev_rd_q || dev_wr_q) |-> (dev_io_q ? (dev_addr_q == gss_pkg::PORT_A_IDX ||
		dev_addr_q == gss_pkg::PORT_B_IDX) : (dev_addr_q == {gss_pkg::CTRL_OFF[6:2], 2'b00} ||
		(dev_addr_q == {gss_pkg::LEN_A_OFF[6:2], 2'b00} && dev_rd_q)));
	endproperty
	a_legal_addr: assert property (p_legal_addr) else $error("illegal engine address");

endmodule
`default_nettype wire

// file: hdl/gss_pkg.sv
// Constants and types for the engine state save controller.
// Assumes the engine's register window is reached by word address plus byte enables.
package gss_pkg;

	// Register window offsets, printed as byte offsets.
	localparam logic [6:0] CTRL_OFF = 7'h11;
	localparam logic [6:0] LEN_A_OFF = 7'h0C;
	localparam logic [6:0] LEN_B_OFF = 7'h0D;
	// Data port indices in the I/O space.
	localparam logic [6:0] PORT_A_IDX = 7'h0C;
	localparam logic [6:0] PORT_B_IDX = 7'h0D;
	localparam int unsigned CTRL_LANE = int'(CTRL_OFF[1:0]);
	localparam int unsigned LENA_LANE = int'(LEN_A_OFF[1:0]);
	localparam int unsigned LENB_LANE = int'(LEN_B_OFF[1:0]);

	// Control byte field positions.
	localparam int unsigned BIT_ACTIVE = 7;
	localparam int unsigned BIT_ABORT = 5;
	localparam int unsigned BIT_HALTED = 4;
	localparam int unsigned BIT_HALT_REQ = 3;
	localparam int unsigned BIT_DIR = 1;
	// Bits that must be written as zero in the control byte.
	localparam logic [7:0] CTRL_ZERO_MASK = 8'hD5;
	localparam logic [3:0] BE_ALL = 4'hF;
	localparam logic [3:0] BE_ONE = 4'h1;

	localparam int unsigned LEN_W = 8;
	localparam int unsigned POLL_MAX_DEF = 1024;
	localparam int unsigned BUF_DEPTH = 2;

	// Commands taken at the user port.
	typedef enum logic [1:0] {
		OP_ABORT = 2'h0,
		OP_SAVE = 2'h1,
		OP_RESTORE = 2'h2,
		OP_RESUME = 2'h3
	} gss_op_t;

endpackage

// file: hdl/gss_sync.sv
// Two-stage synchroniser for signals arriving from the engine pins.
// Assumes each bit is stable long enough to be caught; words need separate qualification.
`timescale 1ns/1ps
`default_nettype none
module gss_sync #(
	parameter int unsigned W = 1
) (
	input wire logic clk_i, // System clock.
	input wire logic rst_i, // Asynchronous reset, active high.
	input wire logic [W-1:0] d_i, // Asynchronous input.
	output logic [W-1:0] q_o // Synchronised output.
);

	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	// The first stage is read only by the second stage.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= d_i;
			sync_q <= meta_q;
		end
	end

	assign q_o = sync_q;

endmodule
`default_nettype wire
